// *** rtl/brcmd_pkg.sv ***
// constants, field positions and carrier types for the bridge command bank
// assumes one 40 MHz clock domain and a 32-bit APB register port
package brcmd_pkg;

  // register map, byte addresses on the APB port
  localparam int unsigned PADDR_W     = 12;
  localparam logic [11:0] CMD_OFFSET  = 12'h000;
  localparam logic [11:0] STAT_OFFSET = 12'h004;

  // command register field positions
  localparam int unsigned IO_EN_BIT   = 0;
  localparam int unsigned MEM_EN_BIT  = 1;
  localparam int unsigned MSTR_EN_BIT = 2;
  localparam int unsigned SPEC_BIT    = 3;
  localparam int unsigned WRINV_BIT   = 4;
  localparam int unsigned PAL_BIT     = 5;
  localparam int unsigned DER_BIT     = 6;

  localparam logic [15:0] CMD_RESET        = 16'h0000;
  localparam logic [15:0] CMD_NATIVE_WMASK = 16'h0047;
  localparam logic [15:0] CMD_LEGACY_WMASK = 16'h0007;

  // status register field positions
  localparam int unsigned STAT_PROFILE_BIT = 0;
  localparam int unsigned STAT_CNT_LSB     = 8;
  localparam int unsigned CNT_W            = 8;

  // decode windows
  localparam int unsigned LEGACY_ADDR_W = 40;
  localparam logic [63:0] MEM_LO = 64'h0000_0000_0000_0000;
  localparam logic [63:0] MEM_HI = 64'h0000_00fc_ffff_ffff;
  localparam logic [63:0] IO_LO  = 64'h0000_00fd_fc00_0000;
  localparam logic [63:0] IO_HI  = 64'h0000_00fd_fdff_ffff;

  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic [63:0] addr;
  } brcmd_pri_req_t;

  typedef struct packed {
    logic valid;
    logic data_err;
  } brcmd_tgt_done_t;

endpackage : brcmd_pkg

// *** rtl/brcmd_win_dec.sv ***
// primary-side address window decoder for the bridge command bank
// assumes the address is stable for the cycle in which it is presented
`timescale 1ns/1ps
module brcmd_win_dec (
  // request address and profile
  input  wire logic [63:0] addr_i,
  input  wire logic        native_i,
  // window hits
  output logic             in_mem_o,
  output logic             in_io_o
);

  function automatic logic in_range(input logic [63:0] a,
                                    input logic [63:0] lo,
                                    input logic [63:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  wire logic [63:0] eff_addr;

  // legacy profile only carries 40 address bits, upper bits are ignored
  assign eff_addr = native_i ? addr_i
                  : {{(64-brcmd_pkg::LEGACY_ADDR_W){1'b0}},
                     addr_i[brcmd_pkg::LEGACY_ADDR_W-1:0]};
  assign in_mem_o = in_range(eff_addr, brcmd_pkg::MEM_LO, brcmd_pkg::MEM_HI);
  assign in_io_o  = in_range(eff_addr, brcmd_pkg::IO_LO, brcmd_pkg::IO_HI);

endmodule : brcmd_win_dec

// *** rtl/brcmd_top.sv ***
// bridge command register bits 6:0 with the gating they apply to traffic
// assumes synchronous inputs on ref_clk_i and an APB master with pstrb
`timescale 1ns/1ps
// Operation
// - legacy profile: bit 6 reads zero, writes to it are dropped
// - native profile: bit 6 writable, forwards TgtDone data errors to secondary
// - bits 6,2,1,0 clear on warm reset and power-up
// - palette snoop bit reads zero; palette writes are never claimed
// - write-invalidate bit reads zero; never generated on secondary
// - special cycle bit tied zero; special cycles never answered
// - initiator bit zero blocks upstream memory and I/O requests
// - initiator bit zero: no target response on secondary bus
// - legacy: memory window disabled refuses requests in its range
// - native: memory window accepts only while its enable is one
// - legacy: I/O window disabled refuses requests in its range
// - native: I/O window accepts only while its enable is one
module brcmd_top #(
  parameter int unsigned CNT_W = brcmd_pkg::CNT_W
) (
  // clock and reset
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         warm_reset_i,
  input  wire logic                         native_profile_strap_i,
  // apb slave
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [brcmd_pkg::PADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                  pwdata_i,
  input  wire logic [3:0]                   pstrb_i,
  output logic [31:0]                       prdata_o,
  output logic                              pready_o,
  output logic                              pslverr_o,
  // primary-side requests
  input  brcmd_pkg::brcmd_pri_req_t         pri_req_i,
  output logic                              pri_accept_o,
  output logic                              pri_refuse_o,
  // primary responses carrying data errors
  input  brcmd_pkg::brcmd_tgt_done_t        tgt_done_i,
  output logic                              sec_data_err_o,
  // secondary-side master requests
  input  wire logic                         sec_req_valid_i,
  input  wire logic                         sec_palette_wr_i,
  input  wire logic                         sec_special_cycle_i,
  output logic                              up_req_valid_o,
  output logic                              sec_target_claim_o,
  output logic                              sec_palette_claim_o,
  output logic                              sec_special_claim_o,
  output logic                              sec_write_inv_o
);

  // command register, only the writable bits are stored
  logic                 primary_error_response_ctl;
  logic                 upstream_initiator_enable;
  logic                 memory_window_enable;
  logic                 io_window_enable;
  logic                 native_link_profile;
  logic                 strap_taken;
  logic [CNT_W-1:0]     refuse_cnt;
  logic                 sec_data_err;
  logic [31:0]          rd_data;

  wire logic            palette_snoop_enable;
  wire logic            write_invalidate_enable;
  wire logic            special_cycle_enable;
  wire logic [15:0]     cmd_view;
  wire logic [15:0]     wmask;
  wire logic [15:0]     next_cmd;
  wire logic [31:0]     stat_view;
  wire logic            hit_cmd;
  wire logic            hit_stat;
  wire logic            mapped;
  wire logic            setup_ph;
  wire logic            access_ph;
  wire logic            cmd_wr;
  wire logic            in_mem;
  wire logic            in_io;
  wire logic            win_hit;
  wire logic            win_en;
  wire logic            der_fwd;

  // hardwired read-only bits
  assign palette_snoop_enable    = 1'b0;
  assign write_invalidate_enable = 1'b0;
  assign special_cycle_enable    = 1'b0;

  assign cmd_view = {9'h000,
                     primary_error_response_ctl,
                     palette_snoop_enable,
                     write_invalidate_enable,
                     special_cycle_enable,
                     upstream_initiator_enable,
                     memory_window_enable,
                     io_window_enable};

  assign stat_view = {16'h0000,
                      refuse_cnt,
                      7'h00,
                      native_link_profile};

  // apb decode
  assign setup_ph  = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i;
  assign hit_cmd   = (paddr_i == brcmd_pkg::CMD_OFFSET);
  assign hit_stat  = (paddr_i == brcmd_pkg::STAT_OFFSET);
  assign mapped    = hit_cmd | hit_stat;
  assign cmd_wr    = access_ph & pwrite_i & hit_cmd & pstrb_i[0];
  assign pready_o  = 1'b1;
  assign pslverr_o = access_ph & ~mapped;

  // bit 6 only takes writes in the native profile; 5:3 never do
  assign wmask    = native_link_profile ? brcmd_pkg::CMD_NATIVE_WMASK
                                        : brcmd_pkg::CMD_LEGACY_WMASK;
  assign next_cmd = (cmd_view & ~wmask) | (pwdata_i[15:0] & wmask);

  // read data is captured in the setup cycle so it is a flop at access
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data <= 32'h0000_0000;
    end else if (setup_ph && !pwrite_i) begin
      rd_data <= hit_cmd  ? {16'h0000, cmd_view}
               : hit_stat ? stat_view
               : 32'h0000_0000;
    end
  end
  assign prdata_o = rd_data;

  // profile strap is caught on the first edge after reset release
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      native_link_profile <= 1'b0;
      strap_taken         <= 1'b0;
    end else if (!strap_taken) begin
      native_link_profile <= native_profile_strap_i;
      strap_taken         <= 1'b1;
    end
  end

  // writable command bits
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      primary_error_response_ctl <= brcmd_pkg::CMD_RESET[brcmd_pkg::DER_BIT];
      upstream_initiator_enable  <= brcmd_pkg::CMD_RESET[brcmd_pkg::MSTR_EN_BIT];
      memory_window_enable       <= brcmd_pkg::CMD_RESET[brcmd_pkg::MEM_EN_BIT];
      io_window_enable           <= brcmd_pkg::CMD_RESET[brcmd_pkg::IO_EN_BIT];
    end else if (warm_reset_i) begin
      primary_error_response_ctl <= brcmd_pkg::CMD_RESET[brcmd_pkg::DER_BIT];
      upstream_initiator_enable  <= brcmd_pkg::CMD_RESET[brcmd_pkg::MSTR_EN_BIT];
      memory_window_enable       <= brcmd_pkg::CMD_RESET[brcmd_pkg::MEM_EN_BIT];
      io_window_enable           <= brcmd_pkg::CMD_RESET[brcmd_pkg::IO_EN_BIT];
    end else if (cmd_wr) begin
      primary_error_response_ctl <= next_cmd[brcmd_pkg::DER_BIT];
      upstream_initiator_enable  <= next_cmd[brcmd_pkg::MSTR_EN_BIT];
      memory_window_enable       <= next_cmd[brcmd_pkg::MEM_EN_BIT];
      io_window_enable           <= next_cmd[brcmd_pkg::IO_EN_BIT];
    end
  end

  // primary window decode
  brcmd_win_dec u_win_dec (
    .addr_i   (pri_req_i.addr),
    .native_i (native_link_profile),
    .in_mem_o (in_mem),
    .in_io_o  (in_io)
  );

  // a request is only claimed when its type matches the window it hits
  assign win_hit      = pri_req_i.is_io ? in_io : in_mem;
  assign win_en       = pri_req_i.is_io ? io_window_enable
                                        : memory_window_enable;
  assign pri_accept_o = pri_req_i.valid & win_hit & win_en;
  assign pri_refuse_o = pri_req_i.valid & ~(win_hit & win_en);

  // saturating count of refused primary requests, for software
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      refuse_cnt <= '0;
    end else if (pri_refuse_o && (refuse_cnt != {CNT_W{1'b1}})) begin
      refuse_cnt <= refuse_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // data error forwarding toward the secondary bus
  assign der_fwd = tgt_done_i.valid & tgt_done_i.data_err
                 & native_link_profile & primary_error_response_ctl;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_data_err <= 1'b0;
    end else begin
      sec_data_err <= der_fwd;
    end
  end
  assign sec_data_err_o = sec_data_err;

  // secondary side gating
  assign up_req_valid_o      = sec_req_valid_i & upstream_initiator_enable;
  assign sec_target_claim_o  = sec_req_valid_i & upstream_initiator_enable;
  assign sec_palette_claim_o = sec_palette_wr_i & palette_snoop_enable;
  assign sec_special_claim_o = sec_special_cycle_i & special_cycle_enable;
  assign sec_write_inv_o     = write_invalidate_enable;

  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_legacy_der_zero: assert property (
    (strap_taken && !native_link_profile) |-> !primary_error_response_ctl)
    else $error("error response bit set in legacy profile");

  a_der_forward_pulse: assert property (
    (tgt_done_i.valid && tgt_done_i.data_err && native_link_profile
     && primary_error_response_ctl) |=> sec_data_err_o)
    else $error("data error not forwarded");

  a_der_no_forward: assert property (
    !primary_error_response_ctl |=> !sec_data_err_o)
    else $error("data error forwarded while disabled");

  a_warm_reset_clear: assert property (
    warm_reset_i |=> (cmd_view == brcmd_pkg::CMD_RESET))
    else $error("command bits survive warm reset");

  a_hardwired_zero: assert property (
    (cmd_view[brcmd_pkg::PAL_BIT] == 1'b0) && !sec_palette_claim_o)
    else $error("palette snoop active");

  a_write_inv_zero: assert property (
    !cmd_view[brcmd_pkg::WRINV_BIT] && !sec_write_inv_o)
    else $error("write invalidate active");

  a_special_never: assert property (
    sec_special_cycle_i |-> !sec_special_claim_o && !cmd_view[brcmd_pkg::SPEC_BIT])
    else $error("special cycle answered");

  a_upstream_block: assert property (
    !upstream_initiator_enable |-> !up_req_valid_o)
    else $error("upstream request while initiator disabled");

  a_sec_target_block: assert property (
    (sec_req_valid_i && !upstream_initiator_enable) |-> !sec_target_claim_o)
    else $error("secondary target claim while disabled");

  a_legacy_mem_refuse: assert property (
    (pri_req_i.valid && !pri_req_i.is_io && !native_link_profile
     && (pri_req_i.addr[39:0] <= brcmd_pkg::MEM_HI[39:0])
     && !memory_window_enable) |-> pri_refuse_o && !pri_accept_o)
    else $error("legacy memory request accepted while disabled");

  a_native_mem_gate: assert property (
    (pri_req_i.valid && !pri_req_i.is_io && native_link_profile
     && (pri_req_i.addr <= brcmd_pkg::MEM_HI))
    |-> (pri_accept_o == memory_window_enable))
    else $error("native memory window gating wrong");

  a_legacy_io_refuse: assert property (
    (pri_req_i.valid && pri_req_i.is_io && !native_link_profile
     && (pri_req_i.addr[39:0] >= brcmd_pkg::IO_LO[39:0])
     && !io_window_enable) |-> pri_refuse_o)
    else $error("legacy I/O request accepted while disabled");

  a_native_io_gate: assert property (
    (pri_req_i.valid && pri_req_i.is_io && native_link_profile
     && (pri_req_i.addr >= brcmd_pkg::IO_LO)
     && (pri_req_i.addr <= brcmd_pkg::IO_HI))
    |-> (pri_accept_o == io_window_enable))
    else $error("native I/O window gating wrong");

  a_write_takes_bits: assert property (
    (cmd_wr && !warm_reset_i) |=>
      (cmd_view[2:0] == $past(pwdata_i[2:0])) && (cmd_view[5:3] == 3'h0))
    else $error("command write not taken as written");

  a_legacy_der_drop: assert property (
    (cmd_wr && !native_link_profile && !warm_reset_i) |=> !primary_error_response_ctl)
    else $error("bit 6 write taken in legacy profile");

  a_legacy_no_forward: assert property (
    !native_link_profile |=> !sec_data_err_o)
    else $error("data error forwarded in legacy profile");

  a_native_der_write: assert property (
    (cmd_wr && native_link_profile && !warm_reset_i)
    |=> (primary_error_response_ctl == $past(pwdata_i[brcmd_pkg::DER_BIT])))
    else $error("bit 6 write lost in native profile");

  a_der_forward_only: assert property (
    sec_data_err_o |-> $past(der_fwd))
    else $error("data error pulse without a forwarded response");

  a_strap_held: assert property (
    strap_taken |=> $stable(native_link_profile))
    else $error("profile changed after strap capture");

  a_upstream_pass: assert property (
    (sec_req_valid_i && upstream_initiator_enable) |-> up_req_valid_o)
    else $error("upstream request dropped while initiator enabled");

  a_claim_needs_req: assert property (
    sec_target_claim_o |-> (sec_req_valid_i && upstream_initiator_enable))
    else $error("secondary claim without an enabled request");

  a_out_of_window: assert property (
    (pri_req_i.valid && !win_hit) |-> (pri_refuse_o && !pri_accept_o))
    else $error("request outside its window accepted");

  a_accept_xor_refuse: assert property (
    pri_req_i.valid |-> (pri_accept_o != pri_refuse_o))
    else $error("request both or neither accepted and refused");

  a_idle_no_answer: assert property (
    !pri_req_i.valid |-> (!pri_accept_o && !pri_refuse_o))
    else $error("answer with no primary request");

  a_strobe_off_hold: assert property (
    (access_ph && pwrite_i && hit_cmd && !pstrb_i[0] && !warm_reset_i)
    |=> $stable(cmd_view))
    else $error("command changed by a write with its strobe off");

  a_cmd_read_data: assert property (
    (setup_ph && !pwrite_i && hit_cmd) |=> (prdata_o == {16'h0000, $past(cmd_view)}))
    else $error("command read data wrong");

  a_unmapped_error: assert property (
    (access_ph && (paddr_i != brcmd_pkg::CMD_OFFSET) && (paddr_i != brcmd_pkg::STAT_OFFSET))
    |-> pslverr_o)
    else $error("unmapped access without slave error");

  a_pready_high: assert property (
    access_ph |-> pready_o)
    else $error("wait state inserted");

  a_refuse_count_step: assert property (
    (pri_refuse_o && (refuse_cnt != {CNT_W{1'b1}}))
    |=> (refuse_cnt == $past(refuse_cnt) + {{(CNT_W-1){1'b0}}, 1'b1}))
    else $error("refusal not counted");

  a_refuse_count_hold: assert property (
    !pri_refuse_o |=> $stable(refuse_cnt))
    else $error("refusal count moved with no refusal");

  c_der_forward: cover property (der_fwd ##1 sec_data_err_o);
  c_refuse:      cover property (pri_req_i.valid && pri_refuse_o);
  c_accept_io:   cover property (pri_req_i.valid && pri_req_i.is_io && pri_accept_o);
  c_upstream:    cover property (cmd_wr ##[1:20] up_req_valid_o);
  c_legacy_drop: cover property (cmd_wr && !native_link_profile
                                 && pwdata_i[brcmd_pkg::DER_BIT]);

endmodule : brcmd_top

// *** verif/brcmd_far_model.sv ***
// primary-link host model: issues window requests and TgtDone responses
// assumes one bench process calls its tasks, so they never overlap
`timescale 1ns/1ps
module brcmd_far_model (
  // clock
  input  wire logic                  clk_i,
  // answers from the bridge
  input  wire logic                  accept_i,
  input  wire logic                  refuse_i,
  input  wire logic                  data_err_i,
  // link traffic toward the bridge
  output brcmd_pkg::brcmd_pri_req_t  pri_req_o,
  output brcmd_pkg::brcmd_tgt_done_t tgt_done_o
);
  initial begin
    pri_req_o  = '0;
    tgt_done_o = '0;
  end

  // idle fields inverted so a stale address or flag cannot mask a fault
  task automatic request(input logic io, input logic [63:0] a, output logic acc,
                         output logic rf);
    @(posedge clk_i);
    pri_req_o <= '{valid: 1'b1, is_io: io, addr: a};
    @(posedge clk_i);
    acc = accept_i;
    rf  = refuse_i;
    pri_req_o <= '{valid: 1'b0, is_io: ~io, addr: ~a};
  endtask : request

  task automatic done(input logic err, output logic fwd);
    @(posedge clk_i);
    tgt_done_o <= '{valid: 1'b1, data_err: err};
    @(posedge clk_i);
    tgt_done_o <= '{valid: 1'b0, data_err: ~err};
    @(posedge clk_i);
    fwd = data_err_i;
  endtask : done
endmodule : brcmd_far_model

// *** verif/test_bridge_command_low_bits.sv ***
// self-checking bench for the bridge command bank, both profiles
// assumes the design answers apb with no wait states but never relies on it
`timescale 1ns/1ps
module test_bridge_command_low_bits;
  typedef struct packed {
    logic        nat;
    logic [2:0]  en;
    logic        io;
    logic [63:0] a;
    logic        acc;
  } brcmd_row_t;

  logic                       ref_clk_i, rst_n_i, warm_reset, strap;
  logic                       psel, penable, pwrite, pready, pslverr;
  logic [11:0]                paddr;
  logic [31:0]                pwdata, prdata, rd;
  logic [3:0]                 pstrb;
  brcmd_pkg::brcmd_pri_req_t  pri_req;
  brcmd_pkg::brcmd_tgt_done_t tgt_done;
  logic                       accept, refuse, sec_err, sec_req, sec_pal, sec_spc;
  logic                       up_req, claim, pal_claim, spc_claim, wr_inv, err, acc, rf;
  int                         fails = 0, num_checks = 0, cycles = 0;
  localparam logic [11:0]     CMD = brcmd_pkg::CMD_OFFSET;
  localparam logic [11:0]     STAT = brcmd_pkg::STAT_OFFSET;

  brcmd_row_t rows [12] = '{
    '{1'b0, 3'h0, 1'b0, 64'h0, 1'b0},
    '{1'b0, 3'h2, 1'b0, 64'h0000_00fc_ffff_ffff, 1'b1},
    '{1'b0, 3'h2, 1'b0, 64'h0000_00fd_0000_0000, 1'b0},
    '{1'b0, 3'h1, 1'b1, 64'h0000_00fd_fc00_0000, 1'b1},
    '{1'b0, 3'h6, 1'b1, 64'h0000_00fd_fc00_0000, 1'b0},
    '{1'b0, 3'h1, 1'b1, 64'h0000_00fd_fdff_ffff, 1'b1},
    '{1'b1, 3'h2, 1'b0, 64'h0000_00fc_ffff_ffff, 1'b1},
    '{1'b1, 3'h5, 1'b0, 64'h0000_0000_1000_0000, 1'b0},
    '{1'b1, 3'h2, 1'b0, 64'h0000_0100_0000_0000, 1'b0},
    '{1'b1, 3'h1, 1'b1, 64'h0000_00fd_fdff_ffff, 1'b1},
    '{1'b1, 3'h6, 1'b1, 64'h0000_00fd_fc00_0000, 1'b0},
    '{1'b1, 3'h3, 1'b1, 64'h0000_00fe_0000_0000, 1'b0}};

  brcmd_top i_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .warm_reset_i(warm_reset),
    .native_profile_strap_i(strap), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .pri_req_i(pri_req), .pri_accept_o(accept), .pri_refuse_o(refuse),
    .tgt_done_i(tgt_done), .sec_data_err_o(sec_err), .sec_req_valid_i(sec_req),
    .sec_palette_wr_i(sec_pal), .sec_special_cycle_i(sec_spc), .up_req_valid_o(up_req),
    .sec_target_claim_o(claim), .sec_palette_claim_o(pal_claim),
    .sec_special_claim_o(spc_claim), .sec_write_inv_o(wr_inv));

  brcmd_far_model i_far (
    .clk_i(ref_clk_i), .accept_i(accept), .refuse_i(refuse), .data_err_i(sec_err),
    .pri_req_o(pri_req), .tgt_done_o(tgt_done));

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    {rst_n_i, warm_reset, strap, psel, penable, pwrite} = '0;
    {sec_req, sec_pal, sec_spc} = '0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // holds the request until pready is sampled high; only the timeout ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] st);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic do_reset(input logic nat);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    strap <= nat;
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
  endtask : do_reset

  task automatic warm_pulse();
    @(posedge ref_clk_i);
    warm_reset <= 1'b1;
    @(posedge ref_clk_i);
    warm_reset <= 1'b0;
    apb(1'b0, CMD, 32'h0, 4'hf);
  endtask : warm_pulse

  task automatic sec_check(input logic en);
    @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    check({27'h0, up_req, claim, pal_claim, spc_claim, wr_inv}, {27'h0, en, en, 3'b000},
          "secondary gating");
  endtask : sec_check

  task automatic run_rows(input logic nat);
    for (int i = 0; i < 12; i++) begin
      if (rows[i].nat === nat) begin
        apb(1'b1, CMD, {29'h0, rows[i].en}, 4'hf);
        i_far.request(rows[i].io, rows[i].a, acc, rf);
        check({31'h0, acc}, {31'h0, rows[i].acc}, "accept");
        check({31'h0, rf}, {31'h0, ~rows[i].acc}, "refuse");
      end
    end
    $display("test windows profile %0d done", nat);
  endtask : run_rows

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // whole run needs under 1500 cycles
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    do_reset(1'b0);
    run_rows(1'b0);
    do_reset(1'b0);
    apb(1'b0, CMD, 32'h0, 4'hf);
    check(rd, 32'h0, "cmd after reset");
    apb(1'b1, CMD, 32'h7f, 4'hf);
    apb(1'b1, CMD, 32'h0, 4'h0);
    apb(1'b0, CMD, 32'h0, 4'hf);
    check(rd, 32'h7, "legacy cmd");
    apb(1'b0, 12'h010, 32'h0, 4'hf);
    check({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
    apb(1'b0, STAT, 32'h0, 4'hf);
    check(rd, 32'h0, "legacy status");
    i_far.done(1'b1, acc);
    check({31'h0, acc}, 32'h0, "legacy error forward");
    sec_req <= 1'b1;
    sec_pal <= 1'b1;
    sec_spc <= 1'b1;
    sec_check(1'b1);
    warm_pulse();
    check(rd, 32'h0, "warm reset legacy");
    sec_check(1'b0);
    $display("test legacy done");
    do_reset(1'b1);
    apb(1'b1, CMD, 32'h7f, 4'hf);
    apb(1'b0, CMD, 32'h0, 4'hf);
    check(rd, 32'h47, "native cmd");
    i_far.done(1'b1, acc);
    check({31'h0, acc}, 32'h1, "error forwarded");
    i_far.done(1'b0, acc);
    check({31'h0, acc}, 32'h0, "no error");
    warm_pulse();
    check(rd, 32'h0, "warm reset native");
    i_far.done(1'b1, acc);
    check({31'h0, acc}, 32'h0, "forward off");
    $display("test native done");
    run_rows(1'b1);
    // status is read-only: the write must neither error nor land
    apb(1'b1, STAT, 32'hffff_ffff, 4'hf);
    check({31'h0, err}, 32'h0, "status write error");
    // four native rows are refused, profile flag set
    apb(1'b0, STAT, 32'h0, 4'hf);
    check(rd, 32'h0000_0401, "native status");
    $display("test status done");
    report_and_stop();
  end
endmodule : test_bridge_command_low_bits
